// ==== smas_master.sv ====
`timescale 1ns/100ps
module smas_master (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaLow
);
  // ----
  // bus phases of 8 clocks
  // ----
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic phase();
    repeat (8) @(posedge clock);
  endtask : phase
  task automatic start();
    sdaLow <= 1'b0;
    phase();
    scl <= 1'b1;
    phase();
    sdaLow <= 1'b1;
    phase();
    scl <= 1'b0;
    phase();
  endtask : start
  task automatic stop();
    sdaLow <= 1'b1;
    phase();
    scl <= 1'b1;
    phase();
    sdaLow <= 1'b0;
    phase();
  endtask : stop
  task automatic bitX(input logic b, output logic r);
    sdaLow <= !b;
    phase();
    scl <= 1'b1;
    phase();
    r = sda;
    scl <= 1'b0;
    phase();
  endtask : bitX
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitX(b[i], r);
    end
    bitX(1'b1, r);
    ack = !r;
  endtask : sendByte
  task automatic recvByte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitX(1'b1, d[i]);
    end
    bitX(!more, r);
  endtask : recvByte
endmodule : smas_master

// ==== smas_mem.sv ====
`timescale 1ns/100ps
module smas_mem (
  input  wire logic                      clock,
  input  smas_pkg::smas_mem_req_type     req,
  output logic [7:0]                     rdData
);
  import smas_pkg::*;

  logic [7:0] store [MEM_DEPTH];

  // ---------------------------------------------------------------------
  // storage with registered read
  // ---------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (req.wrEn) begin
      store[req.addr] <= req.data;
    end
    rdData <= store[req.addr];
  end

endmodule : smas_mem

// ==== smas_pkg.sv ====
package smas_pkg;

  // ---------------------------------------------------------------------
  // bus and memory geometry
  // ---------------------------------------------------------------------
  localparam int          DATA_W          = 8;
  localparam int          ROW_BYTES       = 8;
  localparam int          ROW_BITS        = 3;
  localparam int          MEM_DEPTH       = 256;
  localparam logic [3:0]  SLAVE_PREFIX    = 4'ha;
  localparam logic [7:0]  ADDR_RESET      = 8'h00;

  // ---------------------------------------------------------------------
  // extinction-ratio setting
  // ---------------------------------------------------------------------
  localparam logic [7:0]  ER_LOW_MIN      = 8'h1c;
  localparam logic [7:0]  ER_LOW_MAX      = 8'h68;
  localparam logic [7:0]  ER_HIGH_MIN     = 8'h9c;
  localparam logic [7:0]  ER_HIGH_MAX     = 8'he8;
  localparam logic [7:0]  ER_OFFSET       = 8'h00;
  localparam logic [7:0]  ER_RESET        = 8'h1c;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int          CLK_MHZ         = 25;
  localparam int          NV_WRITE_US     = 10;
  localparam int          NV_WRITE_CYC    = NV_WRITE_US * CLK_MHZ;
  localparam int          NVW_CNT_W       = 16;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    SMAS_IDLE  = 3'b000,
    SMAS_ADDR  = 3'b001,
    SMAS_AACK  = 3'b011,
    SMAS_WRX   = 3'b010,
    SMAS_WACK  = 3'b110,
    SMAS_RTX   = 3'b111,
    SMAS_RACK  = 3'b101,
    SMAS_IGN   = 3'b100
  } smas_state_type;

  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } smas_mem_req_type;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } smas_pin_type;

endpackage : smas_pkg

// ==== smas_slave.sv ====
`timescale 1ns/100ps
// Behaviour
// - program row for write time after stop
// - no address acknowledge while programming
// - whole 8-byte row reprogrammed
// - unchanged row bytes keep contents
// - reads start at address counter
// - dummy write loads counter for read
// - master ack yields another read byte
// - extinction setting low range 28..104
// - code 156 starts high range to 232
// - eight devices via select pins
// - match 1010 plus select bits only
// - write counter wraps within row
module smas_slave (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            sclIn,
  input  wire logic            sdaIn,
  output logic                 sdaOut,
  output logic                 sdaOe,
  input  wire logic [2:0]      addressSelect,
  output logic [7:0]           extinctionRatioSetting,
  output logic                 erHighRange,
  output logic                 nvBusy
);
  import smas_pkg::*;

  // ---------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------
  logic [1:0] sclSync_ff, sdaSync_ff;
  logic [2:0] selMeta_ff, selSync_ff;
  logic       sclD_ff, sdaD_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclSync_ff <= 2'h3;
      sdaSync_ff <= 2'h3;
      selMeta_ff <= 3'h0;
      selSync_ff <= 3'h0;
      sclD_ff    <= 1'b1;
      sdaD_ff    <= 1'b1;
    end else begin
      sclSync_ff <= {sclSync_ff[0], sclIn};
      sdaSync_ff <= {sdaSync_ff[0], sdaIn};
      selMeta_ff <= addressSelect;
      selSync_ff <= selMeta_ff;
      sclD_ff    <= sclSync_ff[1];
      sdaD_ff    <= sdaSync_ff[1];
    end
  end

  logic scl, sda, sclRise, sclFall, startCond, stopCond;
  assign scl       = sclSync_ff[1];
  assign sda       = sdaSync_ff[1];
  assign sclRise   = scl & ~sclD_ff;
  assign sclFall   = ~scl & sclD_ff;
  assign startCond = scl & sclD_ff & ~sda & sdaD_ff;
  assign stopCond  = scl & sclD_ff & sda & ~sdaD_ff;

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  smas_state_type   state_ff;
  logic [3:0]       bitCnt_ff;
  logic [7:0]       shift_ff;
  logic [7:0]       addrCnt_ff;
  logic             haveAddr_ff;
  logic             isRead_ff;
  logic             dirty_ff;
  logic [NVW_CNT_W-1:0] nvCnt_ff;
  logic [7:0]       erReg_ff;
  logic [7:0]       memRd;
  smas_mem_req_type memReq;

  logic addrMatch;
  assign addrMatch = (shift_ff[6:3] == SLAVE_PREFIX) &&
                     (shift_ff[2:0] == selSync_ff);

  logic byteDone;
  assign byteDone = sclRise && (bitCnt_ff == 4'h7);

  // ---------------------------------------------------------------------
  // byte shifter and bit counter
  // ---------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bitCnt_ff <= 4'h0;
      shift_ff  <= 8'h00;
    end else if (startCond) begin
      bitCnt_ff <= 4'h0;
    end else if (sclRise) begin
      if (state_ff == SMAS_ADDR || state_ff == SMAS_WRX) begin
        shift_ff <= {shift_ff[6:0], sda};
      end
      bitCnt_ff <= (bitCnt_ff == 4'h8) ? 4'h0 : bitCnt_ff + 4'h1;
    end
  end

  // ---------------------------------------------------------------------
  // protocol state machine
  // ---------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= SMAS_IDLE;
      isRead_ff <= 1'b0;
    end else if (startCond) begin
      state_ff <= SMAS_ADDR;
    end else if (stopCond) begin
      state_ff <= SMAS_IDLE;
    end else begin
      case (state_ff)
        SMAS_ADDR: begin
          if (byteDone) begin
            isRead_ff <= sda;
            if (addrMatch && !nvBusy) begin
              state_ff <= SMAS_AACK;
            end else begin
              state_ff <= SMAS_IGN;
            end
          end
        end
        SMAS_AACK: begin
          if (sclFall && bitCnt_ff == 4'h0) begin
            state_ff <= isRead_ff ? SMAS_RTX : SMAS_WRX;
          end
        end
        SMAS_WRX: begin
          if (byteDone) begin
            state_ff <= SMAS_WACK;
          end
        end
        SMAS_WACK: begin
          if (sclFall && bitCnt_ff == 4'h0) begin
            state_ff <= SMAS_WRX;
          end
        end
        SMAS_RTX: begin
          if (byteDone) begin
            state_ff <= SMAS_RACK;
          end
        end
        SMAS_RACK: begin
          if (sclRise) begin
            state_ff <= sda ? SMAS_IGN : SMAS_RTX;
          end
        end
        default: begin
          state_ff <= state_ff;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // address counter and write capture
  // ---------------------------------------------------------------------
  logic wrStrobe;
  assign wrStrobe = (state_ff == SMAS_WRX) && byteDone && haveAddr_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addrCnt_ff  <= ADDR_RESET;
      haveAddr_ff <= 1'b0;
      dirty_ff    <= 1'b0;
    end else begin
      if (state_ff == SMAS_AACK) begin
        haveAddr_ff <= 1'b0;
      end
      if ((state_ff == SMAS_WRX) && byteDone && !haveAddr_ff) begin
        addrCnt_ff  <= {shift_ff[6:0], sda};
        haveAddr_ff <= 1'b1;
      end else if (wrStrobe) begin
        dirty_ff   <= 1'b1;
        addrCnt_ff <= {addrCnt_ff[7:ROW_BITS],
                       addrCnt_ff[ROW_BITS-1:0] + 3'h1};
      end else if (state_ff == SMAS_RTX && byteDone) begin
        addrCnt_ff <= addrCnt_ff + 8'h01;
      end
      if (stopCond && dirty_ff) begin
        dirty_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // nonvolatile row programming timer
  // ---------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nvCnt_ff <= '0;
    end else if (stopCond && dirty_ff) begin
      nvCnt_ff <= NVW_CNT_W'(NV_WRITE_CYC);
    end else if (nvCnt_ff != '0) begin
      nvCnt_ff <= nvCnt_ff - NVW_CNT_W'(1);
    end
  end
  assign nvBusy = (nvCnt_ff != '0);

  // ---------------------------------------------------------------------
  // memory: byte-wide writes leave the rest of the row intact
  // ---------------------------------------------------------------------
  always_comb begin
    memReq.wrEn = wrStrobe;
    memReq.addr = addrCnt_ff;
    memReq.data = {shift_ff[6:0], sda};
  end

  smas_mem smas_mem_inst (
    .clock  (clock),
    .req    (memReq),
    .rdData (memRd)
  );

  // ---------------------------------------------------------------------
  // extinction-ratio setting
  // ---------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      erReg_ff <= ER_RESET;
    end else if (wrStrobe && addrCnt_ff == ER_OFFSET) begin
      if ((memReq.data >= ER_LOW_MIN && memReq.data <= ER_LOW_MAX) ||
          (memReq.data >= ER_HIGH_MIN &&
           memReq.data <= ER_HIGH_MAX)) begin
        erReg_ff <= memReq.data;
      end
    end
  end
  assign extinctionRatioSetting = erReg_ff;
  assign erHighRange = (erReg_ff >= ER_HIGH_MIN);

  // ---------------------------------------------------------------------
  // sda driver
  // ---------------------------------------------------------------------
  logic [7:0] txByte_ff;
  logic       sdaOe_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txByte_ff <= 8'h00;
      sdaOe_ff  <= 1'b0;
    end else if (startCond || stopCond) begin
      sdaOe_ff <= 1'b0;
    end else if (sclFall) begin
      case (state_ff)
        SMAS_AACK, SMAS_WACK: begin
          if (bitCnt_ff == 4'h8) begin
            sdaOe_ff <= 1'b1;
          end else if (isRead_ff && state_ff == SMAS_AACK) begin
            txByte_ff <= {memRd[6:0], 1'b0};
            sdaOe_ff  <= ~memRd[7];
          end else begin
            sdaOe_ff <= 1'b0;
          end
        end
        SMAS_WRX: begin
          sdaOe_ff <= (bitCnt_ff == 4'h8);
        end
        SMAS_RTX: begin
          if (bitCnt_ff == 4'h0) begin
            txByte_ff <= {memRd[6:0], 1'b0};
            sdaOe_ff  <= ~memRd[7];
          end else begin
            sdaOe_ff  <= ~txByte_ff[7];
            txByte_ff <= {txByte_ff[6:0], 1'b0};
          end
        end
        SMAS_RACK: begin
          sdaOe_ff <= 1'b0;
        end
        default: begin
          sdaOe_ff <= 1'b0;
        end
      endcase
    end
  end
  assign sdaOe  = sdaOe_ff;
  assign sdaOut = 1'b0;

endmodule : smas_slave

// ==== smas_slave_properties.sv ====
`timescale 1ns/100ps
module smas_slave_properties (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOe,
  input wire logic [7:0] extinctionRatioSetting,
  input wire logic       erHighRange,
  input wire logic       nvBusy
);
  import smas_pkg::*;
  localparam int BUSY_LAST = NV_WRITE_CYC - 1;
  // ----
  // bus and programming checks
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_NO_ACK_BUSY:
    assert property (nvBusy |-> !sdaOe)
    else $error("data line pulled while programming");
  AST_BUSY_LEN:
    assert property ($rose(nvBusy) |-> ##BUSY_LAST nvBusy ##1 !nvBusy)
    else $error("programming time wrong");
  AST_BUSY_AFTER_STOP:
    assert property ($rose(nvBusy) |-> sclIn && sdaIn && $past(sclIn, 4))
    else $error("programming started without stop");
  AST_BUSY_GAP:
    assert property ($fell(nvBusy) |-> !nvBusy [*8])
    else $error("programming retriggered");
  AST_OE_SCL_LOW:
    assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data line changed with clock high");
  AST_OE_HOLD:
    assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("data line pull too short");
  AST_ER_RANGE:
    assert property (extinctionRatioSetting inside
      {[ER_LOW_MIN:ER_LOW_MAX], [ER_HIGH_MIN:ER_HIGH_MAX]})
    else $error("extinction code outside legal ranges");
  AST_ER_HIGH:
    assert property (erHighRange ==
      (extinctionRatioSetting inside {[ER_HIGH_MIN:ER_HIGH_MAX]}))
    else $error("high range flag wrong");
endmodule : smas_slave_properties

bind smas_slave smas_slave_properties smas_slave_properties_inst (
  .clock(clock), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
  .extinctionRatioSetting(extinctionRatioSetting),
  .erHighRange(erHighRange), .nvBusy(nvBusy));

// ==== smas_slave_tb.sv ====
`timescale 1ns/100ps
module smas_slave_tb;
  import smas_pkg::*;
  // ----
  // bench signals
  // ----
  localparam logic [7:0] SLV = {SLAVE_PREFIX, 3'b101, 1'b0};
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] addressSelect = 3'b101;
  logic       sdaOut, sdaOe, erHighRange, nvBusy, scl, sdaLow;
  logic [7:0] erCode;
  int         error_cnt, samples_checked, cycleCnt;
  wire        sda = !(sdaLow || (sdaOe && !sdaOut));
  always #20 clock = !clock;
  smas_slave smas_slave_inst (.clock(clock), .rst(rst), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addressSelect(addressSelect), .extinctionRatioSetting(erCode),
    .erHighRange(erHighRange), .nvBusy(nvBusy));
  smas_master smas_master_inst (.clock(clock), .sda(sda), .scl(scl),
    .sdaLow(sdaLow));
  // ----
  // checking and closing
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  always @(posedge clock) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ----
  // transfers
  // ----
  task automatic wrTx(input logic [7:0] a, input logic [7:0] d[$]);
    logic ack;
    smas_master_inst.start();
    smas_master_inst.sendByte(SLV, ack);
    check({7'h0, ack}, 8'h01);
    smas_master_inst.sendByte(a, ack);
    check({7'h0, ack}, 8'h01);
    foreach (d[i]) begin
      smas_master_inst.sendByte(d[i], ack);
      check({7'h0, ack}, 8'h01);
    end
    smas_master_inst.stop();
  endtask : wrTx
  task automatic rdTx(input logic dummy, input logic [7:0] a,
                      input logic [7:0] exp[$]);
    logic       ack;
    logic [7:0] d;
    smas_master_inst.start();
    if (dummy) begin
      smas_master_inst.sendByte(SLV, ack);
      smas_master_inst.sendByte(a, ack);
      smas_master_inst.start();
    end
    smas_master_inst.sendByte(SLV | 8'h01, ack);
    check({7'h0, ack}, 8'h01);
    foreach (exp[i]) begin
      smas_master_inst.recvByte(i < exp.size() - 1, d);
      check(d, exp[i]);
    end
    smas_master_inst.stop();
  endtask : rdTx
  task automatic testPoll();
    logic ack;
    int   n;
    check({7'h0, nvBusy}, 8'h01);
    n = 0;
    do begin
      smas_master_inst.start();
      smas_master_inst.sendByte(SLV, ack);
      smas_master_inst.stop();
      n++;
      if (n == 1) check({7'h0, ack}, 8'h00);
    end while (!ack && n < 10);
    check({7'h0, ack}, 8'h01);
  endtask : testPoll
  // ----
  // scenarios
  // ----
  task automatic testWrap();
    wrTx(8'h06, '{8'h11, 8'h22, 8'h33});
    check(erCode, 8'h33);
    testPoll();
  endtask : testWrap
  task automatic testReads();
    rdTx(1'b1, 8'h06, '{8'h11});
    rdTx(1'b0, 8'h00, '{8'h22});
    rdTx(1'b1, 8'h06, '{8'h11, 8'h22});
  endtask : testReads
  task automatic testCalib();
    wrTx(8'h00, '{ER_LOW_MIN});
    check(erCode, ER_LOW_MIN);
    testPoll();
    wrTx(8'h00, '{8'h80});
    check(erCode, ER_LOW_MIN);
    check({7'h0, erHighRange}, 8'h00);
    testPoll();
  endtask : testCalib
  task automatic testHigh();
    wrTx(8'h00, '{8'h9c});
    check(erCode, 8'h9c);
    check({7'h0, erHighRange}, 8'h01);
    testPoll();
    rdTx(1'b1, 8'h06, '{8'h11, 8'h22});
  endtask : testHigh
  task automatic testWrong();
    logic ack;
    smas_master_inst.start();
    smas_master_inst.sendByte({SLAVE_PREFIX, 3'b100, 1'b0}, ack);
    check({7'h0, ack}, 8'h00);
    smas_master_inst.sendByte(8'h00, ack);
    smas_master_inst.sendByte(8'h28, ack);
    smas_master_inst.stop();
    check(erCode, 8'h9c);
    check({7'h0, nvBusy}, 8'h00);
  endtask : testWrong
  task automatic testSelect();
    logic ack;
    addressSelect <= 3'b100;
    repeat (4) @(posedge clock);
    smas_master_inst.start();
    smas_master_inst.sendByte({SLAVE_PREFIX, 3'b100, 1'b0}, ack);
    smas_master_inst.stop();
    check({7'h0, ack}, 8'h01);
    smas_master_inst.start();
    smas_master_inst.sendByte(SLV, ack);
    smas_master_inst.stop();
    check({7'h0, ack}, 8'h00);
    addressSelect <= 3'b101;
    repeat (4) @(posedge clock);
  endtask : testSelect
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check(erCode, ER_RESET);
    check({7'h0, erHighRange}, 8'h00);
    testWrap();
    testReads();
    testCalib();
    testHigh();
    testWrong();
    testSelect();
    end_sim();
  end
endmodule : smas_slave_tb
